// file: flux_switch_params.svh
// Behaviour
// R1 - Quantize flux to 10 bits, store digitally
// R2 - Hysteresis from 4-bit converter, held fixed
// R3 - Hysteresis equals 5.0 mT both directions
// R4 - Classify trend against tracked extreme value
// R5 - Fall from peak by hysteresis: output on
// R6 - Rise from minimum by hysteresis: output off
// R7 - Output driver off at power-up
// R8 - Hold output until first minimum found
// R9 - Evaluate every sample, no chopper wait
// R10 - Short circuit: driver off 100 to 200 us
// R11 - Reversed field enters factory test sequence
// R12 - On sinks line low, off releases it
`ifndef FLUX_SWITCH_PARAMS_SVH
`define FLUX_SWITCH_PARAMS_SVH
`define FLUX_WIDTH        10
`define HYST_WIDTH        4
`define HYST_UT           5000
`define HYST_UT_PER_LSB   1000
`define HYST_DEFAULT_CODE 4'h5
`define CLK_MHZ           250
`define FAULT_MIN_US      100
`define FAULT_MAX_US      200
`define FAULT_CYCLES      ((`FAULT_MIN_US + `FAULT_MAX_US) / 2 * `CLK_MHZ)
`define FAULT_CNT_WIDTH   16
`define DRIVE_SETTLE      2'h3
`define TEST_POLARITY_CYCLES 16'h0010
`endif

// file: flux_switch_pkg.sv
package flux_switch_pkg;
    typedef enum {SEEK_MIN, TRACK_RISE, TRACK_FALL} trend_t;
    typedef struct packed {
        logic       valid;
        logic [9:0] flux;
        logic       northPole;
    } sample_t;
endpackage

// file: fault_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "flux_switch_params.svh"
module fault_timer #(
    parameter int unsigned CYCLES = `FAULT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic shortSeen,
    output logic      shutdown
);
    logic [`FAULT_CNT_WIDTH-1:0] count;

    // ****************************************
    // Shutdown interval
    // ****************************************
    // Midpoint of window keeps margin both ways
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (count != '0) begin
            count <= count - 1'b1; // R10
        end else if (shortSeen) begin
            count <= CYCLES[`FAULT_CNT_WIDTH-1:0]; // R10
        end
    end
    assign shutdown = (count != '0);
endmodule
`default_nettype wire

// file: flux_peak_valley_switch.sv
`timescale 1ns/100ps
`default_nettype none
`include "flux_switch_params.svh"
module flux_peak_valley_switch
    import flux_switch_pkg::*;
#(
    parameter int unsigned FAULT_CYCLES = `FAULT_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire sample_t                sample,
    input  wire logic [`HYST_WIDTH-1:0] hystCode,
    input  wire logic                   lineIn,
    output logic                        lineOut,
    output logic                        lineOe_n,
    output logic                        switchOn,
    output logic                        testMode,
    output logic                        shortFault
);
    // ****************************************
    // State and decisions
    // ****************************************
    logic [2:0]             lineSync;
    logic                   lineHigh;
    logic [1:0]             driveAge;
    logic                   driving;
    logic                   shortNow;
    logic                   shutdown;
    logic [`HYST_WIDTH-1:0] hyst;
    logic                   hystLoaded;
    logic [15:0]            northCount;
    logic                   northRun;
    trend_t                 trend;
    logic [`FLUX_WIDTH-1:0] extreme;
    logic                   driveOn;
    logic                   accept;
    logic                   newLow;
    logic                   newHigh;
    logic                   valleyAdvance;
    logic                   peakRetreat;

    // ****************************************
    // Shared arithmetic
    // ****************************************
    // Extra top bit keeps a code near full scale from wrapping
    function automatic logic beyond(input logic [`FLUX_WIDTH-1:0] a,
                                    input logic [`FLUX_WIDTH-1:0] b,
                                    input logic [`HYST_WIDTH-1:0] h);
        beyond = ({1'b0, a} >= ({1'b0, b} + {7'h00, h})); // R3
    endfunction

    // ****************************************
    // Pin synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            lineSync <= 3'h7;
        end else begin
            lineSync <= {lineSync[1:0], lineIn};
        end
    end

    // A high level counts only once the last two stages are both high
    assign lineHigh = lineSync[2] && lineSync[1];

    // ****************************************
    // Short detection
    // ****************************************
    assign driving = driveOn && !shutdown;

    // The stages still hold the released level for a few edges after the
    // sink turns on; judging earlier would trip on every turn-on
    always_ff @(posedge clk) begin
        if (rst) begin
            driveAge <= 2'h0;
        end else if (!driving) begin
            driveAge <= 2'h0;
        end else if (driveAge != `DRIVE_SETTLE) begin
            driveAge <= driveAge + 2'h1;
        end
    end

    // Sinking while the line still reads high means a short to supply
    assign shortNow = driving && (driveAge == `DRIVE_SETTLE) && lineHigh; // R10

    fault_timer #(.CYCLES(FAULT_CYCLES)) uFault (
        .clk      (clk),
        .rst      (rst),
        .shortSeen(shortNow),
        .shutdown (shutdown)
    );

    // ****************************************
    // Hysteresis capture
    // ****************************************
    // Sampled once after reset so a noisy trim cannot move thresholds
    always_ff @(posedge clk) begin
        if (rst) begin
            hyst <= `HYST_DEFAULT_CODE; // R3
        end else if (!hystLoaded) begin
            hyst <= hystCode; // R2
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hystLoaded <= 1'b0;
        end else begin
            hystLoaded <= 1'b1; // R2
        end
    end

    // ****************************************
    // Factory test entry
    // ****************************************
    assign northRun = (northCount == `TEST_POLARITY_CYCLES);

    always_ff @(posedge clk) begin
        if (rst) begin
            northCount <= 16'h0000;
        end else if (sample.valid) begin
            if (!sample.northPole) begin
                northCount <= 16'h0000;
            end else if (!northRun) begin
                northCount <= northCount + 16'h0001;
            end
        end
    end

    // Sticky: only a reset leaves the test sequence
    always_ff @(posedge clk) begin
        if (rst) begin
            testMode <= 1'b0;
        end else if (sample.valid && sample.northPole && northRun) begin
            testMode <= 1'b1; // R11
        end
    end

    // ****************************************
    // Sample judgement
    // ****************************************
    // Every valid sample outside test mode, once hystLoaded is set, is judged at once; no chop phase to wait on
    assign accept = sample.valid && hystLoaded && !testMode; // R9 R11

    always_comb begin
        newLow        = 1'b0;
        newHigh       = 1'b0;
        valleyAdvance = 1'b0;
        peakRetreat   = 1'b0;
        if (accept) begin
            newLow        = (sample.flux < extreme); // R4
            newHigh       = (sample.flux > extreme); // R4
            valleyAdvance = beyond(sample.flux, extreme, hyst); // R6
            peakRetreat   = beyond(extreme, sample.flux, hyst); // R5
        end
    end

    // ****************************************
    // Trend state
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            trend <= SEEK_MIN;
        end else if (accept) begin
            case (trend)
                SEEK_MIN: begin
                    if (valleyAdvance) begin
                        trend <= TRACK_RISE; // R8
                    end
                end
                TRACK_RISE: begin
                    if (peakRetreat) begin
                        trend <= TRACK_FALL; // R5
                    end
                end
                TRACK_FALL: begin
                    if (valleyAdvance) begin
                        trend <= TRACK_RISE; // R6
                    end
                end
                default: begin
                    trend <= SEEK_MIN;
                end
            endcase
        end
    end

    // ****************************************
    // Tracked extreme
    // ****************************************
    // Starts at full scale so any first sample below full scale is a new low
    always_ff @(posedge clk) begin
        if (rst) begin
            extreme <= '1;
        end else if (accept) begin
            case (trend)
                SEEK_MIN, TRACK_FALL: begin
                    if (newLow || valleyAdvance) begin
                        extreme <= sample.flux; // R1 R4
                    end
                end
                TRACK_RISE: begin
                    if (newHigh || peakRetreat) begin
                        extreme <= sample.flux; // R1 R4
                    end
                end
                default: begin
                    extreme <= '1;
                end
            endcase
        end
    end

    // ****************************************
    // Output state
    // ****************************************
    // Nothing switches before the first valley is found
    always_ff @(posedge clk) begin
        if (rst) begin
            driveOn <= 1'b0; // R7
        end else if (accept) begin
            case (trend)
                TRACK_RISE: begin
                    if (peakRetreat) begin
                        driveOn <= 1'b1; // R5
                    end
                end
                TRACK_FALL: begin
                    if (valleyAdvance) begin
                        driveOn <= 1'b0; // R6
                    end
                end
                default: begin
                    driveOn <= driveOn; // R8
                end
            endcase
        end
    end

    // ****************************************
    // Open-drain driver
    // ****************************************
    // Data stays low; the enable alone moves the pin
    assign lineOut    = 1'b0; // R12
    assign lineOe_n   = !driving; // R12 R10
    assign switchOn   = driveOn;
    assign shortFault = shutdown;
endmodule
`default_nettype wire

// file: flux_switch_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "flux_switch_params.svh"
// ****
// Checker
// ****
module flux_switch_props
    import flux_switch_pkg::*;
#(
    parameter int unsigned FAULT_CYCLES = `FAULT_CYCLES
) (
    input wire logic    clk,
    input wire logic    rst,
    input wire sample_t sample,
    input wire logic    lineOut,
    input wire logic    lineOe_n,
    input wire logic    switchOn,
    input wire logic    testMode,
    input wire logic    shortFault
);
    logic [`FAULT_CNT_WIDTH-1:0] faultLen;

    // Counts the cycles of the current shutdown
    always_ff @(posedge clk) begin
        if (rst) begin
            faultLen <= '0;
        end else if (shortFault) begin
            faultLen <= faultLen + 1'b1;
        end else begin
            faultLen <= '0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_DATA_LOW: assert property (lineOut == 1'h0) else $error("data not low");
    AST_SINK_ON: assert property (!shortFault |-> lineOe_n == !switchOn) else $error("enable mismatch");
    AST_FAULT_OFF: assert property (shortFault |-> lineOe_n) else $error("driving in fault");
    AST_FAULT_LEN: assert property ($fell(shortFault) && !$past(rst)
        |-> faultLen == FAULT_CYCLES[`FAULT_CNT_WIDTH-1:0]) else $error("fault length");
    AST_TRIP_SETTLE: assert property ($rose(switchOn) && !shortFault |-> !shortFault[*4]) else $error("early trip");
    AST_RESET_OFF: assert property ($fell(rst) |-> lineOe_n && !switchOn) else $error("on after reset");
    AST_SAMPLE_EDGE: assert property (!sample.valid |=> $stable(switchOn)) else $error("no sample");
    AST_TEST_STICKY: assert property (testMode |=> testMode) else $error("test lost");
    AST_TEST_FREEZE: assert property (testMode |=> $stable(switchOn)) else $error("test toggle");
endmodule
bind flux_peak_valley_switch flux_switch_props #(.FAULT_CYCLES(FAULT_CYCLES)) u_props (.clk(clk), .rst(rst),
    .sample(sample), .lineOut(lineOut), .lineOe_n(lineOe_n), .switchOn(switchOn), .testMode(testMode),
    .shortFault(shortFault));
`default_nettype wire

// file: flux_line_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Output line
// ****
module flux_line_model (
    input  wire logic lineOe_n,
    input  wire logic shortLine,
    output logic      lineIn
);
    // Pull-up lifts a released line; a short to supply beats the sink
    assign lineIn = shortLine | lineOe_n;
endmodule
`default_nettype wire

// file: tb_flux_peak_valley_switch.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench
// ****
module tb_flux_peak_valley_switch
    import flux_switch_pkg::*;
;
    logic    clk, rst, lineIn, lineOut, lineOe_n, switchOn, testMode, shortFault, shortLine;
    sample_t sample;
    logic [3:0] hystCode;
    int      errors, n_tests, k;
    flux_peak_valley_switch #(.FAULT_CYCLES(20)) u_dut (.clk(clk), .rst(rst), .sample(sample), .hystCode(hystCode),
        .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n), .switchOn(switchOn), .testMode(testMode),
        .shortFault(shortFault));
    flux_line_model u_line (.lineOe_n(lineOe_n), .shortLine(shortLine), .lineIn(lineIn));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task check(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task guard(input int lim);
        if (k >= lim) begin
            errors++;
            finish_test();
        end
    endtask
    task send(input logic [9:0] f, input logic np);
        @(posedge clk);
        #1 sample = '{1'h1, f, np};
        @(posedge clk);
        #1 sample.valid = 1'h0;
    endtask
    task peak_valley;
        send(10'h12c, 1'h0);
        hystCode = 4'h1;
        send(10'h064, 1'h0);
        send(10'h068, 1'h0);
        send(10'h069, 1'h0);
        check(switchOn, 10'h0);
        send(10'h0c8, 1'h0);
        send(10'h0c4, 1'h0);
        check(switchOn, 10'h0);
        send(10'h0c3, 1'h0);
        check({switchOn, lineIn}, 10'h2);
        send(10'h096, 1'h0);
        send(10'h09a, 1'h0);
        check(switchOn, 10'h1);
        send(10'h09b, 1'h0);
        check({switchOn, lineOe_n}, 10'h1);
    endtask
    task short_fault;
        send(10'h0c8, 1'h0);
        send(10'h0c3, 1'h0);
        check(lineOe_n, 10'h0);
        shortLine = 1'h1;
        for (k = 0; k < 10 && shortFault !== 1'h1; k++) @(posedge clk) #1;
        guard(10);
        shortLine = 1'h0;
        check(lineOe_n, 10'h1);
        for (k = 0; k < 40 && shortFault === 1'h1; k++) @(posedge clk) #1;
        guard(40);
        check(k inside {[19:21]}, 10'h1);
        check(lineOe_n, 10'h0);
    endtask
    task test_entry;
        repeat (16) send(10'h064, 1'h1);
        check(testMode, 10'h0);
        send(10'h064, 1'h1);
        check(testMode, 10'h1);
        send(10'h3ff, 1'h0);
        send(10'h000, 1'h0);
        check(switchOn, 10'h1);
    endtask
    task reset_again;
        @(posedge clk);
        #1 rst = 1'h1;
        repeat (2) @(posedge clk);
        #1 rst = 1'h0;
        check({switchOn, lineOe_n, testMode, shortFault}, 10'h4);
        check(lineOut, 10'h0);
    endtask
    initial begin
        errors = 0;
        n_tests = 0;
        rst = 1'h1;
        shortLine = 1'h0;
        hystCode = 4'h5;
        sample = '0;
        repeat (2) @(posedge clk);
        #1 rst = 1'h0;
        check({switchOn, lineOe_n}, 10'h1);
        peak_valley();
        short_fault();
        test_entry();
        reset_again();
        finish_test();
    end
endmodule
`default_nettype wire
